// ### logic/base_clock_select_and_output.sv
// Local design decisions: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module base_clock_select_and_output (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// low speed clock levels from outside sources
	input wire logic low_clk_a,
	input wire logic low_clk_b,
	input wire logic low_clk_c,
	// oscillator status
	input wire logic main_clk_stopped,
	// clock controls
	output logic base_src_sel,
	output logic [1:0] base_div,
	output logic [1:0] bus_div,
	output logic pll_run,
	output logic main_osc_disable,
	output logic wdt_clk_bit,
	output logic watchdog_start,
	output logic clock_out_pin
);
	// ************************************
	// synchronisers for external levels
	// ************************************
	logic [3:0] sync1;
	logic [3:0] sync2;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1 <= 4'h0;
			sync2 <= 4'h0;
		end else begin
			sync1 <= {main_clk_stopped, low_clk_c, low_clk_b, low_clk_a};
			sync2 <= sync1;
		end
	end

	// ************************************
	// peripheral dividers
	// ************************************
	clk_div_if div_bus ();
	periph_div u_div (
		.pclk(pclk),
		.presetn(presetn),
		.div(div_bus)
	);

	// ************************************
	// registers
	// ************************************
	logic [1:0] low_sel;
	logic [1:0] out_sel;
	logic pll_stop_bit;
	logic out_q;
	logic wd_pulse;
	logic [1:0] next_base_div;
	logic [1:0] next_bus_div;
	logic next_base_src_sel;
	logic [1:0] next_low_sel;
	logic [1:0] next_out_sel;
	logic next_main_osc_disable;
	logic next_wdt_clk_bit;
	logic next_pll_stop_bit;
	logic next_wd_pulse;
	logic next_out_q;
	logic [31:0] next_prdata;
	logic next_pslverr;
	logic wr;
	logic rd;
	logic low_clk;
	assign wr = psel && penable && pwrite;
	// read data and error load in the setup cycle, so they stand while pready is sampled
	assign rd = psel && !penable && !pwrite;
	assign pready = 1'b1;
	always_comb begin
		next_base_div = base_div;
		next_bus_div = bus_div;
		next_base_src_sel = base_src_sel;
		next_low_sel = low_sel;
		next_out_sel = out_sel;
		next_main_osc_disable = main_osc_disable;
		next_wdt_clk_bit = wdt_clk_bit;
		next_pll_stop_bit = pll_stop_bit;
		next_wd_pulse = 1'b0;
		next_prdata = 32'h00000000;
		next_pslverr = 1'b0;
		if (paddr == clk_sel_pkg::addr_clock_ctrl) begin
			if (wr) begin
				// both divide fields load as written; ordering is software's duty
				next_base_div = pwdata[clk_sel_pkg::base_div_lsb +: 2];
				next_bus_div = pwdata[clk_sel_pkg::bus_div_lsb +: 2];
				// switches base clock to the selected low speed source
				next_base_src_sel = pwdata[clk_sel_pkg::base_src_sel_pos];
			end
			next_prdata[clk_sel_pkg::base_div_lsb +: 2] = base_div;
			next_prdata[clk_sel_pkg::bus_div_lsb +: 2] = bus_div;
			next_prdata[clk_sel_pkg::base_src_sel_pos] = base_src_sel;
		end else if (paddr == clk_sel_pkg::addr_mode_three) begin
			if (wr) begin
				// source choice made here before base_src_sel is set
				next_low_sel = {pwdata[clk_sel_pkg::low_src_sel_hi_pos],
					pwdata[clk_sel_pkg::low_src_sel_lo_pos]};
			end
			next_prdata[clk_sel_pkg::low_src_sel_lo_pos] = low_sel[0];
			next_prdata[clk_sel_pkg::low_src_sel_hi_pos] = low_sel[1];
		end else if (paddr == clk_sel_pkg::addr_mode_zero) begin
			if (wr) begin
				next_out_sel = {pwdata[clk_sel_pkg::out_sel_bit1_pos],
					pwdata[clk_sel_pkg::out_sel_bit0_pos]};
				// halting the main oscillator after a stop is software's choice
				next_main_osc_disable = pwdata[clk_sel_pkg::main_osc_disable_pos];
				// stored whenever written; timing against watchdog start is software's
				next_wdt_clk_bit = pwdata[clk_sel_pkg::wdt_clk_bit_pos];
				next_pll_stop_bit = pwdata[clk_sel_pkg::pll_stop_bit_pos];
			end
			next_prdata[clk_sel_pkg::out_sel_bit0_pos] = out_sel[0];
			next_prdata[clk_sel_pkg::out_sel_bit1_pos] = out_sel[1];
			next_prdata[clk_sel_pkg::main_osc_disable_pos] = main_osc_disable;
			next_prdata[clk_sel_pkg::wdt_clk_bit_pos] = wdt_clk_bit;
			next_prdata[clk_sel_pkg::pll_stop_bit_pos] = pll_stop_bit;
		end else if (paddr == clk_sel_pkg::addr_watchdog_start) begin
			if (wr) begin
				next_wd_pulse = 1'b1;
			end
		end else if (paddr == clk_sel_pkg::addr_status) begin
			next_prdata[0] = sync2[3];
			next_prdata[1] = pll_run;
		end else begin
			next_pslverr = psel && !penable;
		end
		// hardware set wins over a software clear in the same cycle
		if (sync2[3]) begin
			next_pll_stop_bit = 1'b1;
		end
		if (!rd) begin
			next_prdata = prdata;
		end
	end

	// ************************************
	// clock out selection
	// ************************************
	always_comb begin
		case (low_sel)
			2'h0: low_clk = sync2[0];
			2'h1: low_clk = sync2[1];
			default: low_clk = sync2[2];
		endcase
		// low speed, div8 or div32; code 00 holds the pin low
		case (out_sel)
			clk_sel_pkg::out_sel_low: next_out_q = low_clk;
			clk_sel_pkg::out_sel_div8: next_out_q = div_bus.div8_clk;
			clk_sel_pkg::out_sel_div32: next_out_q = div_bus.div32_clk;
			default: next_out_q = 1'b0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			base_div <= clk_sel_pkg::clock_ctrl_reset[1:0];
			bus_div <= clk_sel_pkg::clock_ctrl_reset[3:2];
			base_src_sel <= 1'b0;
			low_sel <= clk_sel_pkg::low_sel_reset;
			out_sel <= clk_sel_pkg::out_sel_reset;
			main_osc_disable <= 1'b0;
			wdt_clk_bit <= 1'b0;
			pll_stop_bit <= 1'b0;
			wd_pulse <= 1'b0;
			out_q <= 1'b0;
			prdata <= 32'h00000000;
			pslverr <= 1'b0;
		end else begin
			base_div <= next_base_div;
			bus_div <= next_bus_div;
			base_src_sel <= next_base_src_sel;
			low_sel <= next_low_sel;
			out_sel <= next_out_sel;
			main_osc_disable <= next_main_osc_disable;
			wdt_clk_bit <= next_wdt_clk_bit;
			pll_stop_bit <= next_pll_stop_bit;
			wd_pulse <= next_wd_pulse;
			out_q <= next_out_q;
			prdata <= next_prdata;
			pslverr <= next_pslverr;
		end
	end

	// pll keeps running while it feeds the base clock
	assign pll_run = !pll_stop_bit || !base_src_sel;
	assign watchdog_start = wd_pulse;
	assign clock_out_pin = out_q;
endmodule // base_clock_select_and_output
`default_nettype wire

// ### logic/clk_sel_pkg.sv
// Function
// - pick low speed source first, then set base source select to one
// - output select pattern 01 drives the chosen low speed clock out
// - clock out carries low speed clock, peripheral div8 or div32
// - pll stop request ignored while base source select is zero
// - main clock stop sets pll stop bit; clear after main clock stable
package clk_sel_pkg;
	// ************************************
	// register map
	// ************************************
	localparam logic [11:0] addr_clock_ctrl = 12'h000;
	localparam logic [11:0] addr_mode_three = 12'h004;
	localparam logic [11:0] addr_mode_zero = 12'h008;
	localparam logic [11:0] addr_watchdog_start = 12'h00c;
	localparam logic [11:0] addr_status = 12'h010;
	// clock_ctrl_reg fields
	localparam int base_div_lsb = 0;
	localparam int bus_div_lsb = 2;
	localparam int base_src_sel_pos = 7;
	// clock_mode_reg_three fields
	localparam int low_src_sel_lo_pos = 0;
	localparam int low_src_sel_hi_pos = 1;
	// clock_mode_reg_zero fields
	localparam int out_sel_bit0_pos = 0;
	localparam int out_sel_bit1_pos = 1;
	localparam int main_osc_disable_pos = 5;
	localparam int wdt_clk_bit_pos = 6;
	localparam int pll_stop_bit_pos = 8;
	// reset values
	localparam logic [7:0] clock_ctrl_reset = 8'h00;
	localparam logic [1:0] low_sel_reset = 2'h0;
	localparam logic [1:0] out_sel_reset = 2'h0;
	// output select codes
	localparam logic [1:0] out_sel_off = 2'h0;
	localparam logic [1:0] out_sel_low = 2'h1;
	localparam logic [1:0] out_sel_div8 = 2'h2;
	localparam logic [1:0] out_sel_div32 = 2'h3;
	// dividers
	localparam logic [4:0] div8_half = 5'h03;
	localparam logic [4:0] div32_half = 5'h0f;
endpackage

// ### logic/clk_div_if.sv
`timescale 1ns/1ns
`default_nettype none
interface clk_div_if;
	logic div8_clk;
	logic div32_clk;
	modport src (output div8_clk, output div32_clk);
	modport dst (input div8_clk, input div32_clk);
endinterface
`default_nettype wire

// ### logic/periph_div.sv
`timescale 1ns/1ns
`default_nettype none
module periph_div (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// divided outputs
	clk_div_if.src div
);
	logic [4:0] cnt8;
	logic [4:0] cnt32;
	logic q8;
	logic q32;
	logic [4:0] next_cnt8;
	logic [4:0] next_cnt32;
	logic next_q8;
	logic next_q32;
	// ************************************
	// toggle dividers: square waves at pclk/8 and pclk/32
	// ************************************
	always_comb begin
		next_cnt8 = cnt8 + 5'h01;
		next_q8 = q8;
		next_cnt32 = cnt32 + 5'h01;
		next_q32 = q32;
		if (cnt8 == clk_sel_pkg::div8_half) begin
			next_cnt8 = 5'h00;
			next_q8 = ~q8;
		end
		if (cnt32 == clk_sel_pkg::div32_half) begin
			next_cnt32 = 5'h00;
			next_q32 = ~q32;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt8 <= 5'h00;
			cnt32 <= 5'h00;
			q8 <= 1'b0;
			q32 <= 1'b0;
		end else begin
			cnt8 <= next_cnt8;
			cnt32 <= next_cnt32;
			q8 <= next_q8;
			q32 <= next_q32;
		end
	end
	assign div.div8_clk = q8;
	assign div.div32_clk = q32;
endmodule // periph_div
`default_nettype wire

// ### tb/clk_sel_properties.sv
`timescale 1ns/1ns
`default_nettype none
module clk_sel_properties (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	// sources
	input wire logic low_clk_a,
	input wire logic low_clk_b,
	input wire logic low_clk_c,
	input wire logic main_clk_stopped,
	// controls
	input wire logic base_src_sel,
	input wire logic pll_run,
	input wire logic clock_out_pin
);
	// ************************************
	// shadow of the output selection
	// ************************************
	logic wr;
	logic lowv;
	logic [1:0] osel;
	logic [1:0] lsel;
	logic [3:0] since;
	assign wr = psel && penable && pwrite;
	assign lowv = lsel == 2'h0 ? low_clk_a : (lsel == 2'h1 ? low_clk_b : low_clk_c);
	// since gives the output mux time to settle after a reselect
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			osel <= 2'h0;
			lsel <= 2'h0;
			since <= 4'h0;
		end else begin
			if (wr && paddr == clk_sel_pkg::addr_mode_three) lsel <= pwdata[1:0];
			if (wr && paddr == clk_sel_pkg::addr_mode_zero) osel <= pwdata[1:0];
			since <= (wr && paddr == clk_sel_pkg::addr_mode_zero) ? 4'h0 : since + 4'(since != 4'hf);
		end
	end
	// ************************************
	// properties
	// ************************************
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_pll_held_on: assert property (!base_src_sel |-> pll_run)
		else $error("pll stopped while it feeds the base clock");
	a_base_src_cause: assert property ($rose(base_src_sel) |->
		$past(wr) && $past(paddr) == clk_sel_pkg::addr_clock_ctrl
		&& $past(pwdata[clk_sel_pkg::base_src_sel_pos]))
		else $error("base source switched without a control write");
	a_stop_on_loss: assert property ((main_clk_stopped && base_src_sel) [*5] |-> !pll_run)
		else $error("pll kept running after main clock loss");
	a_div8_shape: assert property ($rose(clock_out_pin) && osel == clk_sel_pkg::out_sel_div8
		&& since == 4'hf |-> ##1 (clock_out_pin || since != 4'hf) [*3]
		##1 (!clock_out_pin || since != 4'hf))
		else $error("divide by eight output has wrong high time");
	a_div32_half: assert property ($rose(clock_out_pin) && osel == clk_sel_pkg::out_sel_div32
		&& since == 4'hf |-> ##16 ($fell(clock_out_pin) || since != 4'hf))
		else $error("divide by thirty-two output has wrong high time");
	a_low_follow: assert property ((osel == clk_sel_pkg::out_sel_low && since == 4'hf
		&& $stable(lowv)) [*5] |-> clock_out_pin == lowv)
		else $error("clock out does not follow the low speed clock");
endmodule // clk_sel_properties
bind base_clock_select_and_output clk_sel_properties u_props (.pclk, .presetn, .psel,
	.penable, .pwrite, .paddr, .pwdata, .low_clk_a, .low_clk_b, .low_clk_c,
	.main_clk_stopped, .base_src_sel, .pll_run, .clock_out_pin);
`default_nettype wire

// ### tb/tb_base_clock_select_and_output.sv
`timescale 1ns/1ns
`default_nettype none
module tb_base_clock_select_and_output;
	// ************************************
	// harness
	// ************************************
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic low_clk_a = 1'b0;
	logic low_clk_b = 1'b0;
	logic low_clk_c = 1'b0;
	logic main_clk_stopped = 1'b0;
	logic [31:0] prdata, rd;
	logic [1:0] base_div, bus_div;
	logic pready, pslverr, err, base_src_sel, pll_run, main_osc_disable;
	logic wdt_clk_bit, watchdog_start, clock_out_pin;
	int fail_count = 0;
	int num_checks = 0;
	int n;
	int wd_n = 0;
	// address, write data, readback
	logic [75:0] rows [5] = '{{12'h008, 32'h142, 32'h142}, {12'h004, 32'h1, 32'h1},
		{12'h000, 32'h4, 32'h4}, {12'h000, 32'h5, 32'h5}, {12'h000, 32'h85, 32'h85}};
	base_clock_select_and_output uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .low_clk_a, .low_clk_b, .low_clk_c,
		.main_clk_stopped, .base_src_sel, .base_div, .bus_div, .pll_run,
		.main_osc_disable, .wdt_clk_bit, .watchdog_start, .clock_out_pin);
	always #4 pclk = ~pclk;
	always @(posedge pclk) if (watchdog_start === 1'b1) wd_n++;
	// ************************************
	// tasks
	// ************************************
	function automatic logic [31:0] outs();
		return {24'h0, base_src_sel, base_div, bus_div, main_osc_disable, wdt_clk_bit, pll_run};
	endfunction
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	// read data and error are taken at the access edge; one idle edge follows
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		k = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && k < 20) begin
			k++;
			@(posedge pclk);
		end
		if (pready !== 1'b1) fail_count++;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic rises(input int k);
		logic p;
		n = 0;
		p = clock_out_pin;
		repeat (k) begin
			@(posedge pclk);
			if (clock_out_pin === 1'b1 && p === 1'b0) n++;
			p = clock_out_pin;
		end
	endtask
	task automatic results();
		if (fail_count == 0 && num_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	initial begin
		repeat (5000) @(posedge pclk);
		fail_count++;
		results();
	end
	// ************************************
	// scenarios
	// ************************************
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk("reset", 32'h01, outs());
		apb(1'b1, 12'h008, 32'h100);
		chk("stop ignored", 32'h01, outs());
		for (int i = 0; i < 5; i++) begin
			apb(1'b1, rows[i][75:64], rows[i][63:32]);
			apb(1'b0, rows[i][75:64], 32'h0);
			chk("readback", rows[i][31:0], rd);
		end
		chk("low mode", 32'haa, outs());
		apb(1'b1, 12'h008, 32'h042);
		chk("stop cleared", 32'hab, outs());
		repeat (16) @(posedge pclk);
		rises(64);
		chk("div8 rises", 32'd8, 32'(n));
		apb(1'b1, 12'h008, 32'h043);
		repeat (20) @(posedge pclk);
		rises(64);
		chk("div32 rises", 32'd2, 32'(n));
		apb(1'b1, 12'h008, 32'h041);
		// only the b source moves, so following it proves the selection
		repeat (4) begin
			low_clk_b <= ~low_clk_b;
			repeat (8) @(posedge pclk);
			chk("low out", 32'(low_clk_b), 32'(clock_out_pin));
		end
		apb(1'b1, 12'h004, 32'h2);
		low_clk_c <= 1'b1;
		repeat (8) @(posedge pclk);
		chk("low c", 32'h1, 32'(clock_out_pin));
		apb(1'b1, 12'h00c, 32'h0);
		// the pulse is counted at the idle edge; let the counter settle first
		repeat (2) @(posedge pclk);
		chk("wd pulse", 32'd1, 32'(wd_n));
		apb(1'b1, 12'h008, 32'h003);
		chk("wdt bit", 32'ha9, outs());
		main_clk_stopped <= 1'b1;
		repeat (6) @(posedge pclk);
		chk("loss", 32'ha8, outs());
		apb(1'b0, 12'h010, 32'h0);
		chk("status", 32'h1, rd);
		apb(1'b1, 12'h008, 32'h023);
		chk("osc off", 32'hac, outs());
		main_clk_stopped <= 1'b0;
		repeat (4) @(posedge pclk);
		apb(1'b1, 12'h008, 32'h003);
		chk("restart", 32'ha9, outs());
		apb(1'b0, 12'h020, 32'h0);
		chk("unmapped", 32'h1, {rd[30:0], err});
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		chk("reset again", 32'h01, outs());
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		chk("after reset", 32'h01, outs());
		chk("pin off", 32'h0, 32'(clock_out_pin));
		results();
	end
endmodule // tb_base_clock_select_and_output
`default_nettype wire
